// *** hw/smc_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
// Contract
// - identity register reads a fixed code, writes ignored.
// - scratchpad stores and returns any byte, no side effect.
// - bits 2:0 pick active power setting; 000 low, 011 ultra, 100 precision.
// - bits 6:4 pick watch power setting, same codes.
// - high-speed serial enable bit always reads zero.
// - x drive register is write-only, drives x self-test.
// - x bit 2 drives positive, bit 3 negative, both off by default.
// - y drive reads 0x80 in active modes, 0x00 in sleep or standby.
// - y bit 2 drives positive, bit 3 negative, off by default.
// - z bit 2 drives positive, bit 3 negative, off by default.
module smc_regs
	import smc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// operating mode from the mode controller
	input wire logic [2:0] operating_mode_field_i,
	// power settings
	output logic [2:0] active_power_setting_o,
	output logic [2:0] watch_power_setting_o,
	output logic high_speed_serial_enable_o,
	// self-test drives
	output logic x_positive_drive_o,
	output logic x_negative_drive_o,
	output logic y_positive_drive_o,
	output logic y_negative_drive_o,
	output logic z_positive_drive_o,
	output logic z_negative_drive_o,
	// analog gain select from x drive bit 0
	output logic analog_gain_select_o
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0] init3_r;
	logic [7:0] scratchpad_r;
	logic [7:0] pwr_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [2:0] axis_wr;
	logic [7:0] axis_val [3];
	logic [2:0] axis_pos;
	logic [2:0] axis_neg;
	logic [2:0] act_ps_r;
	logic [2:0] watch_ps_r;
	logic hs_r;
	logic [5:0] drv_r;
	logic gain_r;

	// is the device in a running mode
	function automatic logic smc_mode_running(input logic [2:0] m);
		smc_mode_running = (m != SMC_MODE_SLEEP) && (m != SMC_MODE_STANDBY);
	endfunction : smc_mode_running

	// init word three resets to zero and keeps writes; host also loads zeros after reset
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			init3_r <= SMC_RESET_VAL;
		end else if (wr_i && addr_i == SMC_ADDR_INIT3) begin
			init3_r <= wdata_i;
		end
	end

	// scratchpad has no effect on anything else
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scratchpad_r <= SMC_RESET_VAL;
		end else if (wr_i && addr_i == SMC_ADDR_SCRATCHPAD) begin
			scratchpad_r <= wdata_i;
		end
	end

	// power mode: reserved codes are kept as written
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pwr_r <= SMC_RESET_VAL;
		end else if (wr_i && addr_i == SMC_ADDR_PWR) begin
			pwr_r <= wdata_i;
		end
	end

	// ----------------------------------------------------------------
	// three drive axes
	// ----------------------------------------------------------------
	assign axis_wr[0] = wr_i && addr_i == SMC_ADDR_XDRV;
	assign axis_wr[1] = wr_i && addr_i == SMC_ADDR_YDRV;
	assign axis_wr[2] = wr_i && addr_i == SMC_ADDR_ZDRV;

	generate
		for (genvar g = 0; g < 3; g++) begin : g_axis
			smc_drive_axis u_axis (
				.clk_sys_i(clk_sys_i),
				.resetn_i(resetn_i),
				.wr_i(axis_wr[g]),
				.wdata_i(wdata_i),
				.value_o(axis_val[g]),
				.pos_o(axis_pos[g]),
				.neg_o(axis_neg[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	// outputs follow the stored fields, one cycle late so they come from flops
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			act_ps_r <= SMC_PS_LOW;
			watch_ps_r <= SMC_PS_LOW;
			hs_r <= 1'b0;
			drv_r <= '0;
			gain_r <= 1'b0;
		end else begin
			act_ps_r <= pwr_r[SMC_ACT_LSB +: 3];
			watch_ps_r <= pwr_r[SMC_WATCH_LSB +: 3];
			hs_r <= pwr_r[SMC_HS_BIT];
			drv_r <= {axis_neg[2], axis_pos[2], axis_neg[1], axis_pos[1], axis_neg[0], axis_pos[0]};
			gain_r <= axis_val[0][0];
		end
	end

	assign active_power_setting_o = act_ps_r;
	assign watch_power_setting_o = watch_ps_r;
	assign high_speed_serial_enable_o = hs_r;
	assign x_positive_drive_o = drv_r[0];
	assign x_negative_drive_o = drv_r[1];
	assign y_positive_drive_o = drv_r[2];
	assign y_negative_drive_o = drv_r[3];
	assign z_positive_drive_o = drv_r[4];
	assign z_negative_drive_o = drv_r[5];
	assign analog_gain_select_o = gain_r;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// unmapped and write-only addresses read zero
	always_comb begin
		rdata_nxt = 8'h00;
		unique case (addr_i)
			SMC_ADDR_IDENTITY: rdata_nxt = SMC_IDENTITY_VAL;
			SMC_ADDR_INIT3: rdata_nxt = init3_r;
			SMC_ADDR_SCRATCHPAD: rdata_nxt = scratchpad_r;
			SMC_ADDR_PWR: rdata_nxt = pwr_r & SMC_PWR_RD_MASK;
			SMC_ADDR_XDRV: rdata_nxt = 8'h00;
			SMC_ADDR_YDRV: rdata_nxt = smc_mode_running(operating_mode_field_i) ?
				SMC_YDRV_ACTIVE_VAL : SMC_YDRV_IDLE_VAL;
			SMC_ADDR_ZDRV: rdata_nxt = axis_val[2];
			default: rdata_nxt = 8'h00;
		endcase
	end

	// read data only in the cycle after the strobe
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_r <= 8'h00;
		end else if (rd_i) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign rdata_o = rdata_r;

	// ----------------------------------------------------------------
	// checks: register port
	// ----------------------------------------------------------------
	// identity is a constant, whatever was written to it
	AST_ID_READ: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_i && addr_i == SMC_ADDR_IDENTITY |=> rdata_o == SMC_IDENTITY_VAL)
		else $error("identity read wrong");

	// back-to-back write then read must already see the new byte
	AST_SCRATCHPAD_RT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i && addr_i == SMC_ADDR_SCRATCHPAD ##1 rd_i && addr_i == SMC_ADDR_SCRATCHPAD
		|=> rdata_o == $past(wdata_i, 2))
		else $error("scratchpad round trip wrong");

	// enable bit and reserved bit 3 never read back as one
	AST_PWR_RD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_i && addr_i == SMC_ADDR_PWR |=> rdata_o[7] == 1'b0 && rdata_o[3] == 1'b0)
		else $error("power reserved or enable bit reads one");

	// reserved codes are stored, read back and driven alike
	AST_PWR_CODES: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_i && addr_i == SMC_ADDR_PWR |=> rdata_o[2:0] == active_power_setting_o
		&& rdata_o[6:4] == watch_power_setting_o)
		else $error("power codes differ between read-back and outputs");

	// write-only x drive reads as zero
	AST_X_WO: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_i && addr_i == SMC_ADDR_XDRV |=> rdata_o == 8'h00)
		else $error("x drive readable");

	// y read-back follows the mode seen with the strobe, not the stored byte
	AST_Y_RD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_i && addr_i == SMC_ADDR_YDRV |=> rdata_o ==
		(smc_mode_running($past(operating_mode_field_i)) ? 8'h80 : 8'h00))
		else $error("y drive read-back wrong");

	// z read-back and z outputs come from one stored byte
	AST_Z_RD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_i && addr_i == SMC_ADDR_ZDRV |=> rdata_o[3:2] == {z_negative_drive_o, z_positive_drive_o})
		else $error("z read-back disagrees with drive outputs");

	// ----------------------------------------------------------------
	// checks: outputs two cycles after a write
	// ----------------------------------------------------------------
	// active power field
	AST_ACT_PS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i && addr_i == SMC_ADDR_PWR |=> ##1 active_power_setting_o == $past(wdata_i[2:0], 2))
		else $error("active power setting wrong");

	// watch power field
	AST_WATCH_PS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i && addr_i == SMC_ADDR_PWR |=> ##1 watch_power_setting_o == $past(wdata_i[6:4], 2))
		else $error("watch power setting wrong");

	// enable bit reaches its output although it reads back zero
	AST_HS_OUT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i && addr_i == SMC_ADDR_PWR |=> ##1 high_speed_serial_enable_o == $past(wdata_i[7], 2))
		else $error("high-speed enable output wrong");

	// x directions
	AST_X_DRV: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i && addr_i == SMC_ADDR_XDRV |=> ##1 x_positive_drive_o == $past(wdata_i[2], 2)
		&& x_negative_drive_o == $past(wdata_i[3], 2))
		else $error("x drive outputs wrong");

	// x bit 0 feeds the gain select
	AST_X_GAIN: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i && addr_i == SMC_ADDR_XDRV |=> ##1 analog_gain_select_o == $past(wdata_i[0], 2))
		else $error("gain select wrong");

	// y positive direction
	AST_Y_DRV: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i && addr_i == SMC_ADDR_YDRV |=> ##1 y_positive_drive_o == $past(wdata_i[2], 2))
		else $error("y drive output wrong");

	// y negative direction
	AST_Y_NEG: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i && addr_i == SMC_ADDR_YDRV |=> ##1 y_negative_drive_o == $past(wdata_i[3], 2))
		else $error("y negative drive wrong");

	// z positive direction
	AST_Z_POS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i && addr_i == SMC_ADDR_ZDRV |=> ##1 z_positive_drive_o == $past(wdata_i[2], 2))
		else $error("z positive drive wrong");

	// z negative direction
	AST_Z_DRV: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i && addr_i == SMC_ADDR_ZDRV |=> ##1 z_negative_drive_o == $past(wdata_i[3], 2))
		else $error("z drive output wrong");

	// ----------------------------------------------------------------
	// checks: outputs hold unless their own register was written
	// ----------------------------------------------------------------
	// all functional outputs as one word for the side-effect checks
	logic [13:0] out_vec;
	assign out_vec = {act_ps_r, watch_ps_r, hs_r, drv_r, gain_r};

	// dropped identity writes disturb nothing downstream
	AST_ID_QUIET: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i && addr_i == SMC_ADDR_IDENTITY |=> ##1 $stable(out_vec))
		else $error("identity write disturbed an output");

	// scratchpad writes touch nothing but the scratchpad
	AST_SCRATCHPAD_QUIET: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i && addr_i == SMC_ADDR_SCRATCHPAD |=> ##1 $stable(out_vec))
		else $error("scratchpad write disturbed an output");

	// power outputs move only two cycles after a power write
	AST_PWR_HOLD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!(wr_i && addr_i == SMC_ADDR_PWR) |=> ##1 $stable({active_power_setting_o,
		watch_power_setting_o, high_speed_serial_enable_o}))
		else $error("power outputs moved without a write");

	// x outputs move only after an x write
	AST_X_HOLD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!(wr_i && addr_i == SMC_ADDR_XDRV) |=> ##1 $stable({x_positive_drive_o, x_negative_drive_o}))
		else $error("x drive moved without a write");

	// y outputs move only after a y write
	AST_Y_HOLD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!(wr_i && addr_i == SMC_ADDR_YDRV) |=> ##1 $stable({y_positive_drive_o, y_negative_drive_o}))
		else $error("y drive moved without a write");

	// z outputs move only after a z write
	AST_Z_HOLD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!(wr_i && addr_i == SMC_ADDR_ZDRV) |=> ##1 $stable({z_positive_drive_o, z_negative_drive_o}))
		else $error("z drive moved without a write");

	// ----------------------------------------------------------------
	// checks: reset defaults, first edge after release
	// ----------------------------------------------------------------
	// scratchpad, power and z drive bytes back at zero
	AST_RESET_ZERO: assert property (@(posedge clk_sys_i)
		$rose(resetn_i) |-> scratchpad_r == 8'h00 && pwr_r == 8'h00 && axis_val[2] == 8'h00)
		else $error("registers not zero after reset");

	// both power settings back at low power
	AST_PS_DEFAULT: assert property (@(posedge clk_sys_i)
		$rose(resetn_i) |-> active_power_setting_o == SMC_PS_LOW && watch_power_setting_o == SMC_PS_LOW)
		else $error("power settings not low after reset");

	// x drive disabled
	AST_X_DEFAULT: assert property (@(posedge clk_sys_i)
		$rose(resetn_i) |-> !x_positive_drive_o && !x_negative_drive_o)
		else $error("x drive active after reset");

	// y drive disabled
	AST_Y_DEFAULT: assert property (@(posedge clk_sys_i)
		$rose(resetn_i) |-> !y_positive_drive_o && !y_negative_drive_o)
		else $error("y drive active after reset");

	// z drive disabled
	AST_Z_DEFAULT: assert property (@(posedge clk_sys_i)
		$rose(resetn_i) |-> !z_positive_drive_o && !z_negative_drive_o)
		else $error("z drive active after reset");

	// ----------------------------------------------------------------
	// coverage of the main scenarios
	// ----------------------------------------------------------------
	// identity read
	COV_ID: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_i && addr_i == SMC_ADDR_IDENTITY);
	// precision and ultra-low power side by side
	COV_PREC: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		active_power_setting_o == SMC_PS_PREC && watch_power_setting_o == SMC_PS_ULTRA);
	// y read-back in a running mode
	COV_Y_ACTIVE: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_i && addr_i == SMC_ADDR_YDRV && smc_mode_running(operating_mode_field_i));
	// write then read with no gap, the tightest spacing the bus allows
	COV_B2B: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i && addr_i == SMC_ADDR_SCRATCHPAD ##1 rd_i && addr_i == SMC_ADDR_SCRATCHPAD);
	// a reserved code driven out unchanged
	COV_RES_CODE: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		active_power_setting_o == 3'h7);
endmodule : smc_regs
`default_nettype wire

// *** hw/smc_pkg.sv ***
package smc_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] SMC_ADDR_IDENTITY = 8'h18;
	localparam logic [7:0] SMC_ADDR_INIT3 = 8'h1a;
	localparam logic [7:0] SMC_ADDR_SCRATCHPAD = 8'h1b;
	localparam logic [7:0] SMC_ADDR_PWR = 8'h1c;
	localparam logic [7:0] SMC_ADDR_XDRV = 8'h20;
	localparam logic [7:0] SMC_ADDR_YDRV = 8'h21;
	localparam logic [7:0] SMC_ADDR_ZDRV = 8'h22;
	// ----------------------------------------------------------------
	// values and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] SMC_IDENTITY_VAL = 8'h5a; // arbitrary value
	localparam logic [7:0] SMC_RESET_VAL = 8'h00;
	localparam logic [7:0] SMC_PWR_RD_MASK = 8'h77;
	localparam logic [7:0] SMC_YDRV_ACTIVE_VAL = 8'h80;
	localparam logic [7:0] SMC_YDRV_IDLE_VAL = 8'h00;
	localparam int SMC_POS_BIT = 2;
	localparam int SMC_NEG_BIT = 3;
	localparam int SMC_ACT_LSB = 0;
	localparam int SMC_WATCH_LSB = 4;
	localparam int SMC_HS_BIT = 7;
	// power setting codes
	localparam logic [2:0] SMC_PS_LOW = 3'h0;
	localparam logic [2:0] SMC_PS_ULTRA = 3'h3;
	localparam logic [2:0] SMC_PS_PREC = 3'h4;
	// operating mode codes seen on the mode input
	localparam logic [2:0] SMC_MODE_SLEEP = 3'h0;
	localparam logic [2:0] SMC_MODE_STANDBY = 3'h1;
endpackage : smc_pkg

// *** hw/smc_drive_axis.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// one axis of self-test drive: stores bits and exposes directions
// ----------------------------------------------------------------
module smc_drive_axis
	import smc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// write side
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	// stored value and directions
	output logic [7:0] value_o,
	output logic pos_o,
	output logic neg_o
);
	logic [7:0] value_r;

	// direction bits default to disabled
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			value_r <= SMC_RESET_VAL;
		end else if (wr_i) begin
			value_r <= wdata_i;
		end
	end

	assign value_o = value_r;
	assign pos_o = value_r[SMC_POS_BIT];
	assign neg_o = value_r[SMC_NEG_BIT];
endmodule : smc_drive_axis
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import smc_pkg::*;
	// ----------------------------------------------------------------
	// stimulus, observed outputs and tallies
	// ----------------------------------------------------------------
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [2:0] mode_i = 3'h0;
	logic [7:0] rdata_o;
	logic [2:0] act_o, wat_o;
	logic hs_o, xp_o, xn_o, yp_o, yn_o, zp_o, zn_o, ag_o;
	int fails = 0;
	int n_checks = 0;
	logic [2:0] pc [4] = '{SMC_PS_LOW, SMC_PS_ULTRA, SMC_PS_PREC, 3'h7};
	// 20 MHz system clock
	always #25 clk_sys_i = ~clk_sys_i;
	smc_regs uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .operating_mode_field_i(mode_i),
		.active_power_setting_o(act_o), .watch_power_setting_o(wat_o), .high_speed_serial_enable_o(hs_o),
		.x_positive_drive_o(xp_o), .x_negative_drive_o(xn_o), .y_positive_drive_o(yp_o),
		.y_negative_drive_o(yn_o), .z_positive_drive_o(zp_o), .z_negative_drive_o(zn_o),
		.analog_gain_select_o(ag_o));
	// ----------------------------------------------------------------
	// bus cycles and comparisons
	// ----------------------------------------------------------------
	task automatic finish_test;
		if (fails == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp8
	// output vector: act, watch, hs, xp, xn, yp, yn, zp, zn, gain
	task automatic outs(input logic [13:0] exp);
		logic [13:0] got;
		@(posedge clk_sys_i);
		#1;
		got = {act_o, wat_o, hs_o, xp_o, xn_o, yp_o, yn_o, zp_o, zn_o, ag_o};
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : outs
	// a spare cycle after each strobe so no signal is assigned twice at one edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		cmp8(rdata_o, exp);
	endtask : rd
	task automatic do_reset;
		@(posedge clk_sys_i);
		resetn_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
	endtask : do_reset
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		do_reset();
		wr(SMC_ADDR_INIT3, 8'h00);
		outs(14'h0000);
		rd(SMC_ADDR_SCRATCHPAD, 8'h00);
		rd(SMC_ADDR_PWR, 8'h00);
		rd(SMC_ADDR_ZDRV, 8'h00);
		rd(SMC_ADDR_INIT3, 8'h00);
	endtask : t_reset
	task automatic t_ident;
		rd(SMC_ADDR_IDENTITY, SMC_IDENTITY_VAL);
		wr(SMC_ADDR_IDENTITY, 8'hff);
		rd(SMC_ADDR_IDENTITY, SMC_IDENTITY_VAL);
		rd(8'h1d, 8'h00);
		rd(8'h23, 8'h00);
	endtask : t_ident
	task automatic t_scratchpad;
		wr(SMC_ADDR_SCRATCHPAD, 8'ha5);
		rd(SMC_ADDR_SCRATCHPAD, 8'ha5);
		wr(SMC_ADDR_SCRATCHPAD, 8'h5a);
		rd(SMC_ADDR_SCRATCHPAD, 8'h5a);
		// write then read with no gap, as the bus allows
		@(posedge clk_sys_i);
		wr_i <= 1'b1;
		addr_i <= SMC_ADDR_SCRATCHPAD;
		wdata_i <= 8'h3c;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		cmp8(rdata_o, 8'h3c);
		outs(14'h0000);
	endtask : t_scratchpad
	// every named code in each field, plus a reserved one, with bits 7 and 3 set
	task automatic t_power;
		for (int i = 0; i < 4; i++) begin
			wr(SMC_ADDR_PWR, {1'b1, pc[3 - i], 1'b1, pc[i]});
			outs({pc[i], pc[3 - i], 1'b1, 7'h00});
			rd(SMC_ADDR_PWR, {1'b0, pc[3 - i], 1'b0, pc[i]});
		end
		wr(SMC_ADDR_PWR, 8'h00);
		outs(14'h0000);
	endtask : t_power
	task automatic t_xdrv;
		wr(SMC_ADDR_XDRV, 8'h0d);
		outs({7'h00, 7'b1100001});
		rd(SMC_ADDR_XDRV, 8'h00);
		wr(SMC_ADDR_XDRV, 8'h09);
		outs({7'h00, 7'b0100001});
	endtask : t_xdrv
	// read-back follows the operating mode, not the written value
	task automatic t_ydrv;
		wr(SMC_ADDR_YDRV, 8'h84);
		outs({7'h00, 7'b0110001});
		for (int m = 0; m < 8; m++) begin
			@(posedge clk_sys_i);
			mode_i <= m[2:0];
			rd(SMC_ADDR_YDRV, (m[2:0] == SMC_MODE_SLEEP || m[2:0] == SMC_MODE_STANDBY) ?
				SMC_YDRV_IDLE_VAL : SMC_YDRV_ACTIVE_VAL);
		end
		wr(SMC_ADDR_YDRV, 8'h88);
		outs({7'h00, 7'b0101001});
	endtask : t_ydrv
	task automatic t_zdrv;
		wr(SMC_ADDR_ZDRV, 8'h04);
		outs({7'h00, 7'b0101101});
		rd(SMC_ADDR_ZDRV, 8'h04);
		wr(SMC_ADDR_ZDRV, 8'h08);
		outs({7'h00, 7'b0101011});
		rd(SMC_ADDR_ZDRV, 8'h08);
	endtask : t_zdrv
	// second reset in mid-run after everything was written
	task automatic t_rereset;
		wr(SMC_ADDR_SCRATCHPAD, 8'hff);
		wr(SMC_ADDR_PWR, 8'h34);
		do_reset();
		wr(SMC_ADDR_INIT3, 8'h00);
		outs(14'h0000);
		rd(SMC_ADDR_INIT3, 8'h00);
		rd(SMC_ADDR_SCRATCHPAD, 8'h00);
		rd(SMC_ADDR_PWR, 8'h00);
		rd(SMC_ADDR_ZDRV, 8'h00);
	endtask : t_rereset
	// ----------------------------------------------------------------
	// main sequence and hang guard
	// ----------------------------------------------------------------
	initial begin
		t_reset();
		t_ident();
		t_scratchpad();
		t_power();
		t_xdrv();
		t_ydrv();
		t_zdrv();
		t_rereset();
		finish_test();
	end
	// whole run needs about 130 cycles; this bound only cuts a hang
	initial begin
		repeat (5000) @(posedge clk_sys_i);
		fails++;
		finish_test();
	end
endmodule : testbench
`default_nettype wire
